/* verilog/frame_cfg_regs.svh */
// Purpose: Register map, field positions, reset values and duty codes of the frame config block
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes: Duty codes are in steps of 0.125 percent (800 equals 100 percent)
// Operation
// R01: Turn angle is the zero cross angle plus the 11-bit offset.
// R02: Fault enable 0 ignores the fault; 1 reports it when both report bits set.
// R03: Overflow 72.5, temperature 66.875, field high 61.25 percent duty.
// R04: Saturation 55.625, soft memory error 50, field low 44.375 percent duty.
// R05: Undervoltage 38.75, averaging 33.125, zero crossing 27.5 percent duty.
// R06: PLL lock loss 21.875, self test 16.25, hard memory error 10.625 percent.
// R07: Oscillator fault forces 5 percent duty when enabled and reporting is on.
// R08: Slot counter wraps to 0 after the highest bus slot.
// R09: Slot sync with marking resyncs from marks; without it stay off bus.
// R10: Tick period is N clocks, at least two clocks.
// R11: With slot marking, response delay after addressing follows own address.
// R12: Mode 000 off, 001 streaming, 010 streaming with pause pulse.
// R13: Mode 011 samples at status nibble end, 100 on trigger after width.
// R14: Modes 101 addressed, 110 sequential bus, 111 long sequential bus.
// R15: PWM select drives PWM and disables frames whatever the mode.
// R16: With PWM and frames off, pin is SPI output unless Manchester active.
// R17: Highest enabled active fault sets the reported duty.
// R18: Mode and tick changes apply only at a frame boundary.
`ifndef FRAME_CFG_REGS_SVH
`define FRAME_CFG_REGS_SVH
`define IDX_PWM_FAULT_EN 8'h18
`define IDX_FRAME_CTL 8'h19
`define IDX_OUT_CTL 8'h30
`define IDX_STATUS 8'h31
`define PFE_RESET 24'h001FFF
`define FOC_RESET 26'h0000000
`define OUT_CTL_RESET 3'h0
`define FOC_MAXID 25:24
`define FOC_SS 23
`define FOC_TICK 22:16
`define FOC_SM 15
`define FOC_MODE 14:12
`define PFE_ZOFS 23:13
`define PFE_EN 12:0
`define OUT_PWM_SEL 0
`define OUT_REP_A 1
`define OUT_REP_B 2
`define TICK_MIN 7'h02
`define DUTY_TOV 10'h244
`define DUTY_TR 10'h217
`define DUTY_MSH 10'h1EA
`define DUTY_SAT 10'h1BD
`define DUTY_ESE 10'h190
`define DUTY_MSL 10'h163
`define DUTY_UV 10'h136
`define DUTY_AVG 10'h109
`define DUTY_ZIE 10'h0DC
`define DUTY_PLK 10'h0AF
`define DUTY_STF 10'h082
`define DUTY_EUE 10'h055
`define DUTY_OFE 10'h028
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* verilog/frame_cfg_pkg.sv */
// Purpose: Types shared by the frame config block
// Assumes: Constants come from frame_cfg_regs.svh
// Notes: Mode codes follow the frame_output_control mode field
package frame_cfg_pkg;
  typedef enum logic [2:0] {
    MODE_OFF, MODE_STREAM, MODE_STREAM_PAUSE, MODE_TRIG_SCN,
    MODE_TRIG_EDGE, MODE_ADDRESSED, MODE_SEQ_BUS, MODE_SEQ_LONG
  } frame_mode_t;
  typedef enum {RSP_IDLE, RSP_DELAY} rsp_state_t;
endpackage : frame_cfg_pkg

/* verilog/output_fault_and_frame_config.sv */
// Purpose: Output fault reporting and frame control registers with their behaviour
// Assumes: AXI4-Lite slave on clk; fault, angle and frame engine inputs are on clk
// Notes: Only the trigger pin and the reset release cross in from outside and are synchronised
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`include "frame_cfg_regs.svh"
module output_fault_and_frame_config #(
  parameter int TRIG_MIN_CYCLES = 16,
  parameter int SLOT_MARK_TICKS = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [12:0] fault_active,
  input wire logic [10:0] zero_cross_angle,
  input wire logic frame_boundary,
  input wire logic scn_end,
  input wire logic trigger_pin,
  input wire logic addr_pulse,
  input wire logic mark_seen,
  input wire logic [1:0] mark_slot,
  input wire logic [1:0] bus_address,
  input wire logic manchester_active,
  output logic [10:0] turn_angle,
  output logic pwm_fault_force,
  output logic [9:0] pwm_fault_duty,
  output logic pwm_drive,
  output logic sent_enable,
  output logic spi_miso_select,
  output logic pause_enable,
  output logic [2:0] active_mode,
  output logic tick_en,
  output logic sample_pulse,
  output logic respond_pulse,
  output logic [1:0] slot_count,
  output logic on_bus
);
  generate
    if (TRIG_MIN_CYCLES < 1 || TRIG_MIN_CYCLES > 255 || SLOT_MARK_TICKS < 1
        || SLOT_MARK_TICKS > 255) begin : g_bad
      $error("parameter out of range");
    end
  endgenerate

  typedef struct packed {
    logic [7:0] aw_addr;
    logic aw_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_got;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [25:0] foc;
    logic [23:0] pfe;
    logic [2:0] out_ctl;
    logic [2:0] act_mode;
    logic [6:0] act_tick;
    logic [6:0] tick_cnt;
    logic tick_en;
    logic [10:0] angle;
    logic force_duty;
    logic [9:0] duty;
    logic [1:0] slot;
    logic synced;
    frame_cfg_pkg::rsp_state_t rsp_state;
    logic [9:0] rsp_cnt;
    logic respond;
    logic trig_s1;
    logic trig_s2;
    logic [7:0] trig_low;
    logic sample;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic rst_s1;
  logic rst_n_s;
  logic [12:0] en_faults;
  logic seq_mode;
  logic [6:0] tick_eff;

  // Reset released through two flops so every state flop leaves reset together
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n_s <= rst_s1;
    end
  end

  // Merge write data into a register under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = wd[i*8 +: 8];
    end
    return res;
  endfunction : merge

  // Byte address of a register index
  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction : byte_addr

  // Duty code of the highest enabled active fault; higher bit wins
  function automatic logic [10:0] pick_duty(input logic [12:0] act);
    logic [10:0] res;
    res = 11'h000;
    if (act[0]) res = {1'b1, `DUTY_OFE}; // R07
    if (act[1]) res = {1'b1, `DUTY_EUE}; // R06
    if (act[2]) res = {1'b1, `DUTY_STF}; // R06
    if (act[3]) res = {1'b1, `DUTY_PLK}; // R06
    if (act[4]) res = {1'b1, `DUTY_ZIE}; // R05
    if (act[5]) res = {1'b1, `DUTY_AVG}; // R05
    if (act[6]) res = {1'b1, `DUTY_UV}; // R05
    if (act[7]) res = {1'b1, `DUTY_MSL}; // R04
    if (act[8]) res = {1'b1, `DUTY_ESE}; // R04
    if (act[9]) res = {1'b1, `DUTY_SAT}; // R04
    if (act[10]) res = {1'b1, `DUTY_MSH}; // R03
    if (act[11]) res = {1'b1, `DUTY_TR}; // R03
    if (act[12]) res = {1'b1, `DUTY_TOV}; // R03
    return res;
  endfunction : pick_duty

  // Faults reach the output only when both report bits are set
  assign en_faults = (st_reg.out_ctl[`OUT_REP_A] && st_reg.out_ctl[`OUT_REP_B]) ?
                     (fault_active & st_reg.pfe[`PFE_EN]) : 13'h0000; // R02
  assign seq_mode = st_reg.act_mode == 3'(frame_cfg_pkg::MODE_SEQ_BUS) ||
                    st_reg.act_mode == 3'(frame_cfg_pkg::MODE_SEQ_LONG); // R14
  assign tick_eff = (st_reg.act_tick < `TICK_MIN) ? `TICK_MIN : st_reg.act_tick; // R10

  // Next state of bus slave, configuration and frame control
  always_comb begin
    logic [10:0] dsel;
    logic [31:0] wr;
    dsel = pick_duty(en_faults); // R17
    wr = 32'h00000000;
    st_next = st_reg;
    st_next.tick_en = 1'b0;
    st_next.respond = 1'b0;
    st_next.sample = 1'b0;
    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_addr = s_axi_awaddr;
      st_next.aw_got = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
      st_next.w_got = 1'b1;
    end
    if (st_reg.aw_got && st_reg.w_got) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = `RESP_OKAY;
      if (st_reg.aw_addr == byte_addr(`IDX_PWM_FAULT_EN)) begin
        wr = merge({8'h00, st_reg.pfe}, st_reg.w_data, st_reg.w_strb);
        st_next.pfe = wr[23:0];
      end else if (st_reg.aw_addr == byte_addr(`IDX_FRAME_CTL)) begin
        wr = merge({6'h00, st_reg.foc}, st_reg.w_data, st_reg.w_strb);
        st_next.foc = wr[25:0];
      end else if (st_reg.aw_addr == byte_addr(`IDX_OUT_CTL)) begin
        wr = merge({29'h00000000, st_reg.out_ctl}, st_reg.w_data, st_reg.w_strb);
        st_next.out_ctl = wr[2:0];
      end else if (st_reg.aw_addr != byte_addr(`IDX_STATUS)) begin
        st_next.bresp = `RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) st_next.bvalid = 1'b0;
    // Read channel: one cycle from address to data
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = `RESP_OKAY;
      if (s_axi_araddr == byte_addr(`IDX_PWM_FAULT_EN)) st_next.rdata = {8'h00, st_reg.pfe};
      else if (s_axi_araddr == byte_addr(`IDX_FRAME_CTL)) st_next.rdata = {6'h00, st_reg.foc};
      else if (s_axi_araddr == byte_addr(`IDX_OUT_CTL)) begin
        st_next.rdata = {29'h00000000, st_reg.out_ctl};
      end else if (s_axi_araddr == byte_addr(`IDX_STATUS)) begin
        st_next.rdata = {8'h00, st_reg.synced, st_reg.slot, st_reg.act_tick,
                         st_reg.act_mode, st_reg.force_duty, st_reg.duty};
      end else begin
        st_next.rdata = 32'h00000000;
        st_next.rresp = `RESP_SLVERR;
      end
    end
    if (st_reg.rvalid && s_axi_rready) st_next.rvalid = 1'b0;
    // Offset added ahead of turns counting to move the turn boundary
    st_next.angle = zero_cross_angle + st_reg.pfe[`PFE_ZOFS]; // R01
    // Fault duty held while the fault stays active
    st_next.force_duty = dsel[10]; // R02
    st_next.duty = dsel[9:0]; // R17
    // Mode and tick adopted only between frames, so no frame is cut short
    if (frame_boundary || st_reg.act_mode == 3'(frame_cfg_pkg::MODE_OFF)) begin
      st_next.act_mode = st_reg.foc[`FOC_MODE]; // R18
      st_next.act_tick = st_reg.foc[`FOC_TICK]; // R18
    end
    // Tick keeps its pace across a boundary, so no tick is stretched; idle while off
    if (st_reg.act_mode == 3'(frame_cfg_pkg::MODE_OFF)) begin
      st_next.tick_cnt = 7'h00;
    end else if (st_reg.tick_cnt >= tick_eff - 7'h01) begin
      st_next.tick_cnt = 7'h00;
      st_next.tick_en = 1'b1; // R10
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 7'h01;
    end
    // Trigger pin passes two flops before the width counter sees it
    st_next.trig_s1 = trigger_pin;
    st_next.trig_s2 = st_reg.trig_s1;
    if (st_reg.trig_s2) st_next.trig_low = 8'h00;
    else if (st_reg.trig_low != 8'hFF) st_next.trig_low = st_reg.trig_low + 8'h01;
    if (st_reg.act_mode == 3'(frame_cfg_pkg::MODE_TRIG_SCN)) begin
      st_next.sample = scn_end; // R13
    end else if (st_reg.act_mode == 3'(frame_cfg_pkg::MODE_TRIG_EDGE)) begin
      st_next.sample = !st_reg.trig_s2 && st_reg.trig_low == 8'(TRIG_MIN_CYCLES - 1); // R13
    end
    // Slot sync from marks; without it the device never rejoins the bus
    if (seq_mode && st_reg.foc[`FOC_SS] && st_reg.foc[`FOC_SM] && mark_seen) begin
      st_next.slot = mark_slot; // R09
      st_next.synced = 1'b1; // R09
    end else if (seq_mode && addr_pulse) begin
      st_next.slot = (st_reg.slot >= st_reg.foc[`FOC_MAXID]) ? 2'h0 : st_reg.slot + 2'h1; // R08
    end
    // Response delay after addressing; a later address pulse is ignored until done
    case (st_reg.rsp_state)
      frame_cfg_pkg::RSP_IDLE: begin
        if (seq_mode && addr_pulse && st_reg.synced && st_reg.slot == bus_address) begin
          if (st_reg.foc[`FOC_SM]) begin
            st_next.rsp_cnt = 10'((32'(bus_address) + 1) * SLOT_MARK_TICKS); // R11
            st_next.rsp_state = frame_cfg_pkg::RSP_DELAY;
          end else begin
            st_next.respond = 1'b1;
          end
        end
      end
      frame_cfg_pkg::RSP_DELAY: begin
        if (st_reg.tick_en) st_next.rsp_cnt = st_reg.rsp_cnt - 10'h001;
        if (st_reg.rsp_cnt == 10'h000) begin
          st_next.respond = 1'b1; // R11
          st_next.rsp_state = frame_cfg_pkg::RSP_IDLE;
        end
      end
      default: st_next.rsp_state = frame_cfg_pkg::RSP_IDLE;
    endcase
  end

  // All block state in one register
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st_reg <= '0;
      st_reg.pfe <= `PFE_RESET;
      st_reg.foc <= `FOC_RESET;
      st_reg.out_ctl <= `OUT_CTL_RESET;
      st_reg.trig_s1 <= 1'b1;
      st_reg.trig_s2 <= 1'b1;
      st_reg.rsp_state <= frame_cfg_pkg::RSP_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Handshake outputs; one write and one read at a time
  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  // Output precedence: PWM first, then frames, then SPI unless Manchester owns the pin
  assign pwm_drive = st_reg.out_ctl[`OUT_PWM_SEL]; // R15
  assign sent_enable = !st_reg.out_ctl[`OUT_PWM_SEL] &&
                       st_reg.act_mode != 3'(frame_cfg_pkg::MODE_OFF); // R15
  assign spi_miso_select = !pwm_drive && !sent_enable && !manchester_active; // R16
  assign pause_enable = st_reg.act_mode == 3'(frame_cfg_pkg::MODE_STREAM_PAUSE); // R12
  assign active_mode = st_reg.act_mode; // R14
  assign turn_angle = st_reg.angle;
  assign pwm_fault_force = st_reg.force_duty;
  assign pwm_fault_duty = st_reg.duty;
  assign tick_en = st_reg.tick_en && sent_enable;
  assign sample_pulse = st_reg.sample;
  assign respond_pulse = st_reg.respond && sent_enable;
  assign slot_count = st_reg.slot;
  assign on_bus = st_reg.synced;

  angle_offset_a: assert property (@(posedge clk) disable iff (!rst_n_s) // R01
    turn_angle == 11'($past(zero_cross_angle) + $past(st_reg.pfe[`PFE_ZOFS])))
    else $error("turn angle offset wrong");
  fault_gate_a: assert property (@(posedge clk) disable iff (!rst_n_s) // R02
    pwm_fault_force |-> $past(st_reg.out_ctl[`OUT_REP_A] && st_reg.out_ctl[`OUT_REP_B]))
    else $error("fault reported with reporting off");
  top_fault_a: assert property (@(posedge clk) disable iff (!rst_n_s) // R03
    $past(en_faults[12]) |-> pwm_fault_duty == `DUTY_TOV)
    else $error("overflow duty wrong");
  osc_only_a: assert property (@(posedge clk) disable iff (!rst_n_s) // R07
    $past(en_faults == 13'h0001) |-> pwm_fault_force && pwm_fault_duty == `DUTY_OFE)
    else $error("oscillator duty wrong");
  slot_wrap_a: assert property (@(posedge clk) disable iff (!rst_n_s) // R08
    (seq_mode && addr_pulse && !mark_seen) |=> slot_count <= $past(st_reg.foc[`FOC_MAXID]))
    else $error("slot counter beyond highest slot");
  tick_min_a: assert property (@(posedge clk) disable iff (!rst_n_s) // R10
    st_reg.tick_en |=> !st_reg.tick_en)
    else $error("tick shorter than two clocks");
  mode_hold_a: assert property (@(posedge clk) disable iff (!rst_n_s) // R18
    ($changed(active_mode) && $past(active_mode) != 3'h0) |-> $past(frame_boundary))
    else $error("mode changed inside a frame");
  pwm_prec_a: assert property (@(posedge clk) disable iff (!rst_n_s) // R15
    pwm_drive |-> !sent_enable && !spi_miso_select)
    else $error("frames or SPI active under PWM");
endmodule : output_fault_and_frame_config

/* tb/frame_rx_partner.sv */
// Purpose: Frame engine stand-in that marks frame ends for the config block
// Assumes: One frame lasts FRAME_TICKS tick pulses while frames own the pin
// Notes: hold swallows boundaries so a bench can keep a frame open on purpose
`timescale 1ns/100ps
module frame_rx_partner #(
  parameter int FRAME_TICKS = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick_en,
  input wire logic sent_enable,
  input wire logic hold,
  output logic frame_boundary
);
  int cnt;
  // Count ticks of the current frame and flag its end for one cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      frame_boundary <= 1'h0;
    end else begin
      frame_boundary <= 1'h0;
      if (sent_enable && tick_en) begin
        if (cnt == FRAME_TICKS - 1) begin
          cnt <= 0;
          frame_boundary <= !hold; // A held frame stays open
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule : frame_rx_partner

/* tb/output_fault_and_frame_config_tb_top.sv */
// Purpose: Self-checking bench for the output fault and frame config block
// Assumes: Inputs change after rising edges; outputs sampled at falling edges
// Notes: Short trigger and slot-mark counts keep the run small
`timescale 1ns/100ps
`include "frame_cfg_regs.svh"
module output_fault_and_frame_config_tb_top;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, sl, slot_count;
  logic [12:0] fault_active = 13'h0, en, fa;
  logic [10:0] zero_cross_angle = 11'h0, z, turn_angle;
  logic scn_end = 1'h0, trigger_pin = 1'h1, addr_pulse = 1'h0, mark_seen = 1'h0;
  logic manchester_active = 1'h0, hold = 1'h0, frame_boundary;
  logic [1:0] mark_slot = 2'h0, bus_address = 2'h1;
  logic pwm_fault_force, pwm_drive, sent_enable, spi_miso_select, pause_enable;
  logic tick_en, sample_pulse, respond_pulse, on_bus;
  logic [9:0] pwm_fault_duty;
  logic [2:0] active_mode, md, prev;
  int err_total = 0, checked = 0, seed = 32'hd912;
  int n, k, g, tk = 0, rtk = 0, nresp = 0, nsmp = 0;
  logic [9:0] dtab [13] = '{`DUTY_OFE, `DUTY_EUE, `DUTY_STF, `DUTY_PLK, `DUTY_ZIE, `DUTY_AVG,
    `DUTY_UV, `DUTY_MSL, `DUTY_ESE, `DUTY_SAT, `DUTY_MSH, `DUTY_TR, `DUTY_TOV};

  always #10 clk = ~clk;

  output_fault_and_frame_config #(.TRIG_MIN_CYCLES(4), .SLOT_MARK_TICKS(2)) dut (
    .clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .fault_active(fault_active), .zero_cross_angle(zero_cross_angle),
    .frame_boundary(frame_boundary), .scn_end(scn_end), .trigger_pin(trigger_pin),
    .addr_pulse(addr_pulse), .mark_seen(mark_seen), .mark_slot(mark_slot),
    .bus_address(bus_address), .manchester_active(manchester_active),
    .turn_angle(turn_angle), .pwm_fault_force(pwm_fault_force),
    .pwm_fault_duty(pwm_fault_duty), .pwm_drive(pwm_drive), .sent_enable(sent_enable),
    .spi_miso_select(spi_miso_select), .pause_enable(pause_enable),
    .active_mode(active_mode), .tick_en(tick_en), .sample_pulse(sample_pulse),
    .respond_pulse(respond_pulse), .slot_count(slot_count), .on_bus(on_bus));

  frame_rx_partner #(.FRAME_TICKS(4)) far (.clk(clk), .reset_n(reset_n), .tick_en(tick_en),
    .sent_enable(sent_enable), .hold(hold), .frame_boundary(frame_boundary));

  // Ticks since the last addressing pulse; falling edge avoids racing the design
  always @(negedge clk) begin
    tk <= addr_pulse ? 0 : tk + int'(tick_en);
    if (respond_pulse) rtk <= tk;
    nresp <= nresp + int'(respond_pulse);
    nsmp <= nsmp + int'(sample_pulse);
  end

  task automatic test_done();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Every wait is bounded; running out is a mismatch and ends the run
  task automatic lim(input int c);
    if (c > 600) begin
      chk(c, 600);
      test_done();
    end
  endtask : lim

  function automatic logic [7:0] ba(input logic [7:0] i);
    return {i[5:0], 2'h0};
  endfunction : ba

  function automatic logic [31:0] fc(input logic [6:0] t, input logic [2:0] m);
    return {6'h0, 2'h1, 1'h1, t, 1'h1, m, 12'h0};
  endfunction : fc

  // Highest active enabled fault sets the duty
  function automatic logic [9:0] xd(input logic [12:0] f, input logic [12:0] e);
    xd = 10'h0;
    for (int i = 0; i < 13; i++) if (f[i] & e[i]) xd = dtab[i];
  endfunction : xd

  // Write: offer address and data together, release each when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, sa, sw, sb;
    int c;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    {ta, tw, sb} = 3'h0;
    c = 0;
    while (!(ta && tw)) begin
      @(negedge clk);
      sa = s_axi_awready & ~ta;
      sw = s_axi_wready & ~tw;
      @(posedge clk);
      if (sa) s_axi_awvalid <= 1'h0;
      if (sw) s_axi_wvalid <= 1'h0;
      ta = ta | sa;
      tw = tw | sw;
      c++;
      lim(c);
    end
    s_axi_bready <= 1'h1;
    while (!sb) begin
      @(negedge clk);
      sb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk);
      c++;
      lim(c);
    end
    s_axi_bready <= 1'h0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    logic sa, sr;
    int c;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    sr = 1'h0;
    c = 0;
    while (!sr) begin
      @(negedge clk);
      sa = s_axi_arready;
      sr = s_axi_rvalid;
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (sa) s_axi_arvalid <= 1'h0;
      c++;
      lim(c);
    end
    s_axi_rready <= 1'h0;
  endtask : axr

  task automatic pulse_trig(input int c);
    @(posedge clk);
    trigger_pin <= 1'h0;
    repeat (c) @(posedge clk);
    trigger_pin <= 1'h1;
    repeat (20) @(posedge clk);
  endtask : pulse_trig

  // Main sequence: defaults, modes, pin ownership, faults, tick period
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    repeat (5) @(posedge clk);
    axr(ba(`IDX_PWM_FAULT_EN));
    chk(rdv, `PFE_RESET);
    axr(ba(`IDX_FRAME_CTL));
    chk(rdv, `FOC_RESET);
    axr(8'h10);
    chk(rsp, `RESP_SLVERR);
    axw(8'h10, 32'h5);
    chk(rsp, `RESP_SLVERR);
    @(posedge clk);
    s_axi_wstrb <= 4'h1;
    axw(ba(`IDX_PWM_FAULT_EN), 32'hFFFFFF00);
    @(posedge clk);
    s_axi_wstrb <= 4'hF;
    axr(ba(`IDX_PWM_FAULT_EN));
    chk(rdv, 32'h00001F00);
    axw(ba(`IDX_OUT_CTL), 32'h6);
    prev = 3'h0;
    for (int m = 1; m < 9; m++) begin
      md = 3'(m);
      @(posedge clk);
      hold <= 1'h1;
      axw(ba(`IDX_FRAME_CTL), fc(7'h2, md));
      @(negedge clk);
      if (prev != 3'h0) chk(active_mode, prev);
      @(posedge clk);
      hold <= 1'h0;
      n = 0;
      while (active_mode !== md) begin
        @(negedge clk);
        n++;
        lim(n);
      end
      chk(active_mode, md);
      chk(pause_enable, md == 3'h2);
      if (md == 3'h3) begin
        @(posedge clk);
        scn_end <= 1'h1;
        @(posedge clk);
        scn_end <= 1'h0;
        @(negedge clk);
        chk(sample_pulse, 1);
      end
      if (md == 3'h4) begin
        k = nsmp;
        pulse_trig(3);
        chk(nsmp - k, 0);
        pulse_trig(12);
        chk(nsmp - k, 1);
      end
      if (md == 3'h6) begin
        @(negedge clk);
        chk(on_bus, 0);
        @(posedge clk);
        mark_seen <= 1'h1;
        @(posedge clk);
        mark_seen <= 1'h0;
        @(negedge clk);
        chk(on_bus, 1);
        sl = 2'h0;
        repeat (3) begin
          @(posedge clk);
          addr_pulse <= 1'h1;
          @(posedge clk);
          addr_pulse <= 1'h0;
          sl = (sl == 2'h1) ? 2'h0 : sl + 2'h1;
          repeat (40) @(negedge clk);
          chk(slot_count, sl);
        end
        chk(nresp > 0 && rtk inside {[3:4]}, 1);
      end
      prev = md;
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      manchester_active <= i[1];
      if (i == 4) axw(ba(`IDX_FRAME_CTL), fc(7'h2, 3'h1));
      axw(ba(`IDX_OUT_CTL), {29'h0, 2'h3, i[0]});
      @(negedge clk);
      chk(pwm_drive, i[0]);
      chk(sent_enable, i > 3 && !i[0]);
      chk(spi_miso_select, i < 4 && i[1:0] == 2'h0);
    end
    for (int r = 0; r < 30; r++) begin
      en = (r == 13) ? 13'h1FFF : (r == 14) ? 13'h0 : 13'($random(seed));
      fa = (r < 13) ? 13'h1 << r : (r < 15) ? 13'h1FFF : 13'($random(seed));
      z = 11'($random(seed));
      axw(ba(`IDX_PWM_FAULT_EN), {8'h0, z, (r < 13) ? 13'h1FFF : en});
      @(posedge clk);
      fault_active <= fa;
      zero_cross_angle <= 11'($random(seed));
      repeat (2) @(negedge clk);
      if (r < 13) chk(pwm_fault_duty, dtab[r]);
      else chk(pwm_fault_duty, xd(fa, en));
      chk(turn_angle, 11'(zero_cross_angle + z));
    end
    for (int c = 0; c < 4; c++) begin
      axw(ba(`IDX_OUT_CTL), {29'h0, 2'(c), 1'h0});
      repeat (2) @(negedge clk);
      chk(pwm_fault_force, c == 3 && (fault_active & en) != 13'h0);
    end
    for (int i = 0; i < 5; i++) begin
      g = (i < 4) ? i : 4 + ($random(seed) & 32'h1F);
      axw(ba(`IDX_FRAME_CTL), fc(7'(g), 3'h1));
      repeat (600) @(negedge clk);
      n = 0;
      while (!tick_en) begin
        @(negedge clk);
        n++;
        lim(n);
      end
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (!tick_en && k < 300);
      chk(k, (g < 2) ? 2 : g);
    end
    axr(ba(`IDX_STATUS));
    chk(rdv[23:11], {1'h1, 2'h1, 7'(g), 3'h1});
    test_done();
  end
endmodule : output_fault_and_frame_config_tb_top
